// ---- dpac_consts.svh ----
// Constants for the dual-port RAM address counter
`ifndef DPAC_CONSTS_SVH
`define DPAC_CONSTS_SVH
`define DPAC_ADDR_W 15
`define DPAC_DATA_W 18
`define DPAC_ADDR_RST 15'h0000
`define DPAC_PIPE_LAT 1
`endif

// ---- dpac_pkg.sv ----
// Types for the dual-port RAM address counter
`include "dpac_consts.svh"
package dpac_pkg;
    typedef enum logic [1:0] {
        DPAC_OP_HOLD,
        DPAC_OP_LOAD,
        DPAC_OP_INCR,
        DPAC_OP_CLEAR
    } dpac_op_t;
    typedef struct packed {
        logic addr_load_strobe_n;
        logic count_advance_n;
        logic count_clear_n;
    } dpac_ctl_t;
endpackage

// ---- dpac_sync2.sv ----
// Two-stage synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module dpac_sync2 #(
    parameter int W = 1
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_ff;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            meta_ff <= '0;
            q <= '0;
        end else begin
            meta_ff <= d;
            q <= meta_ff;
        end
    end
endmodule

// ---- dpac_addr_counter.sv ----
// Port address counter with flow-through or pipelined read data
`timescale 1ns/1ps
`include "dpac_consts.svh"
module dpac_addr_counter #(
    parameter int AW = `DPAC_ADDR_W,
    parameter int DW = `DPAC_DATA_W
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [AW-1:0] ext_addr,
    input wire logic addr_load_strobe_n,
    input wire logic count_advance_n,
    input wire logic count_clear_n,
    input wire logic flowthrough_or_pipelined_sel,
    input wire logic [DW-1:0] mem_rdata,
    output logic [AW-1:0] int_addr_ff,
    output logic [DW-1:0] rdata_ff,
    output logic pipelined_ff
);
    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [AW+3:0] pin_s;
    dpac_sync2 #(.W(AW + 4)) u_sync (
        .ref_clk(ref_clk),
        .srst(srst),
        .d({ext_addr, addr_load_strobe_n, count_advance_n, count_clear_n,
            flowthrough_or_pipelined_sel}),
        .q(pin_s)
    );
    dpac_pkg::dpac_ctl_t ctl;
    logic [AW-1:0] ext_addr_s;
    logic pipe_sel_s;
    assign ext_addr_s = pin_s[AW+3:4];
    assign ctl = dpac_pkg::dpac_ctl_t'(pin_s[3:1]);
    assign pipe_sel_s = pin_s[0];

    ////////////////////////////////////////////////////////////////////////////
    // Counter operation decode
    dpac_pkg::dpac_op_t op;
    always_comb begin
        if (!ctl.count_clear_n) begin
            op = dpac_pkg::DPAC_OP_CLEAR;
        end else if (!ctl.addr_load_strobe_n) begin
            op = dpac_pkg::DPAC_OP_LOAD;
        end else if (!ctl.count_advance_n) begin
            op = dpac_pkg::DPAC_OP_INCR;
        end else begin
            op = dpac_pkg::DPAC_OP_HOLD;
        end
    end

    logic [AW-1:0] nxt_int_addr;
    always_comb begin
        case (op)
            dpac_pkg::DPAC_OP_CLEAR: nxt_int_addr = AW'(`DPAC_ADDR_RST);
            dpac_pkg::DPAC_OP_LOAD: nxt_int_addr = ext_addr_s;
            dpac_pkg::DPAC_OP_INCR: nxt_int_addr = AW'(int_addr_ff + 1'b1);
            dpac_pkg::DPAC_OP_HOLD: nxt_int_addr = int_addr_ff;
            default: nxt_int_addr = int_addr_ff;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Address register
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            int_addr_ff <= AW'(`DPAC_ADDR_RST);
        end else begin
            int_addr_ff <= nxt_int_addr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output mode and read data stages
    logic [DW-1:0] stage_ff;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pipelined_ff <= 1'b0;
        end else begin
            pipelined_ff <= pipe_sel_s;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            stage_ff <= '0;
            rdata_ff <= '0;
        end else begin
            stage_ff <= mem_rdata;
            rdata_ff <= pipe_sel_s ? stage_ff : mem_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Burst tracker: start address and steps since the last load or clear
    logic [AW-1:0] burst_base_ff;
    logic [AW-1:0] burst_steps_ff;
    logic [AW-1:0] nxt_burst_base;
    logic [AW-1:0] nxt_burst_steps;
    always_comb begin
        nxt_burst_base = burst_base_ff;
        nxt_burst_steps = burst_steps_ff;
        case (op)
            dpac_pkg::DPAC_OP_CLEAR: begin
                nxt_burst_base = AW'(`DPAC_ADDR_RST);
                nxt_burst_steps = '0;
            end
            dpac_pkg::DPAC_OP_LOAD: begin
                nxt_burst_base = ext_addr_s;
                nxt_burst_steps = '0;
            end
            dpac_pkg::DPAC_OP_INCR: begin
                nxt_burst_steps = AW'(burst_steps_ff + 1'b1);
            end
            dpac_pkg::DPAC_OP_HOLD: begin
                nxt_burst_steps = burst_steps_ff;
            end
            default: begin
                nxt_burst_base = burst_base_ff;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            burst_base_ff <= '0;
            burst_steps_ff <= '0;
        end else begin
            burst_base_ff <= nxt_burst_base;
            burst_steps_ff <= nxt_burst_steps;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    chk_clear_zero: assert property (@(posedge ref_clk) disable iff (srst)
        !ctl.count_clear_n |=> int_addr_ff == '0)
        else $error("clear did not zero address");
    chk_load_addr: assert property (@(posedge ref_clk) disable iff (srst)
        ctl.count_clear_n && !ctl.addr_load_strobe_n |=> int_addr_ff == $past(ext_addr_s))
        else $error("load did not take external address");
    chk_incr_wrap: assert property (@(posedge ref_clk) disable iff (srst)
        ctl.count_clear_n && ctl.addr_load_strobe_n && !ctl.count_advance_n
        |=> int_addr_ff == AW'($past(int_addr_ff) + 1'b1))
        else $error("advance did not increment");
    chk_hold_addr: assert property (@(posedge ref_clk) disable iff (srst)
        ctl.count_clear_n && ctl.addr_load_strobe_n && ctl.count_advance_n
        |=> $stable(int_addr_ff))
        else $error("hold changed address");
    chk_wrap_top: assert property (@(posedge ref_clk) disable iff (srst)
        op == dpac_pkg::DPAC_OP_INCR && &int_addr_ff |=> int_addr_ff == '0)
        else $error("counter did not wrap");
    chk_flow_data: assert property (@(posedge ref_clk) disable iff (srst)
        !pipe_sel_s |=> rdata_ff == $past(mem_rdata))
        else $error("flow-through data wrong");
    chk_pipe_data: assert property (@(posedge ref_clk) disable iff (srst)
        pipe_sel_s && $past(!srst) |=> rdata_ff == $past(mem_rdata, 2))
        else $error("pipelined data not one cycle later");
    chk_mode_track: assert property (@(posedge ref_clk) disable iff (srst)
        $past(!srst) |-> pipelined_ff == $past(pipe_sel_s))
        else $error("mode flag wrong");

    ////////////////////////////////////////////////////////////////////////////
    // Priority and burst checks
    chk_clear_priority: assert property (@(posedge ref_clk) disable iff (srst)
        !ctl.count_clear_n && !ctl.addr_load_strobe_n |=> int_addr_ff == '0)
        else $error("clear lost to load");
    chk_load_priority: assert property (@(posedge ref_clk) disable iff (srst)
        ctl.count_clear_n && !ctl.addr_load_strobe_n && !ctl.count_advance_n
        |=> int_addr_ff == $past(ext_addr_s))
        else $error("load lost to advance");
    chk_ext_blocked: assert property (@(posedge ref_clk) disable iff (srst)
        op == dpac_pkg::DPAC_OP_HOLD && ext_addr_s != int_addr_ff
        |=> int_addr_ff != $past(ext_addr_s))
        else $error("hold took external address");
    chk_incr_ignores: assert property (@(posedge ref_clk) disable iff (srst)
        op == dpac_pkg::DPAC_OP_INCR && ext_addr_s != AW'(int_addr_ff + 1'b1)
        |=> int_addr_ff != $past(ext_addr_s))
        else $error("advance took external address");
    chk_burst_sum: assert property (@(posedge ref_clk) disable iff (srst)
        int_addr_ff == AW'(burst_base_ff + burst_steps_ff))
        else $error("address differs from burst start plus steps");

    ////////////////////////////////////////////////////////////////////////////
    // Read data and reset checks
    chk_stage_track: assert property (@(posedge ref_clk) disable iff (srst)
        $past(!srst) |-> stage_ff == $past(mem_rdata))
        else $error("pipeline stage wrong");
    chk_flag_flow: assert property (@(posedge ref_clk) disable iff (srst)
        $past(!srst) && !pipelined_ff |-> rdata_ff == $past(mem_rdata))
        else $error("flow-through flag and data disagree");
    chk_flag_pipe: assert property (@(posedge ref_clk) disable iff (srst)
        $past(!srst) && pipelined_ff |-> rdata_ff == $past(stage_ff))
        else $error("pipelined flag and data disagree");
    chk_pipe_switch: assert property (@(posedge ref_clk) disable iff (srst)
        $rose(pipe_sel_s) |=> rdata_ff == $past(stage_ff))
        else $error("mode switch data wrong");
    chk_reset_clean: assert property (@(posedge ref_clk)
        $past(srst) |-> int_addr_ff == '0 && rdata_ff == '0 && !pipelined_ff)
        else $error("outputs not cleared by reset");

    ////////////////////////////////////////////////////////////////////////////
    // Cover points
    cov_load: cover property (@(posedge ref_clk) op == dpac_pkg::DPAC_OP_LOAD);
    cov_burst: cover property (@(posedge ref_clk)
        op == dpac_pkg::DPAC_OP_INCR [*3]);
    cov_wrap: cover property (@(posedge ref_clk)
        op == dpac_pkg::DPAC_OP_INCR && &int_addr_ff);
    cov_pipe_clear: cover property (@(posedge ref_clk)
        pipe_sel_s && op == dpac_pkg::DPAC_OP_CLEAR);
    cov_mode_switch: cover property (@(posedge ref_clk)
        $rose(pipelined_ff));
endmodule

// ---- dpac_mem_model.sv ----
// Read-only memory stand-in on the far side of the counter
`timescale 1ns/1ps
module dpac_mem_model (
    input wire logic [14:0] addr,
    output logic [17:0] rdata
);
    // Pattern per address, never written during loads
    assign rdata = {3'h5, ~addr};
endmodule

// ---- dpac_addr_counter_bench.sv ----
// Self-checking bench for the port address counter
`timescale 1ns/1ps
module dpac_addr_counter_bench;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic [14:0] ext_addr = 15'h0000;
    dpac_pkg::dpac_ctl_t ctl = 3'h7;
    logic sel = 1'b0;
    logic [17:0] mem_rdata;
    logic [14:0] int_addr;
    logic [17:0] rdata;
    logic pipe;
    int errors = 0;
    int tests_run = 0;
    dpac_addr_counter uut (.ref_clk(ref_clk), .srst(srst), .ext_addr(ext_addr),
        .addr_load_strobe_n(ctl.addr_load_strobe_n), .count_advance_n(ctl.count_advance_n),
        .count_clear_n(ctl.count_clear_n), .flowthrough_or_pipelined_sel(sel),
        .mem_rdata(mem_rdata), .int_addr_ff(int_addr), .rdata_ff(rdata),
        .pipelined_ff(pipe));
    dpac_mem_model mem (.addr(int_addr), .rdata(mem_rdata));
    initial forever #20 ref_clk = ~ref_clk;
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic go(input logic [2:0] c, input int n);
        ctl = c;
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic t_load;
        ext_addr = 15'h7FFF;
        go(3'b011, 1);
        go(3'b111, 4);
        chk(int_addr, 15'h7FFF);
        go(3'b101, 2);
        go(3'b111, 4);
        chk(int_addr, 15'h0001);
        ext_addr = 15'h1234;
        go(3'b111, 5);
        chk(int_addr, 15'h0001);
        ext_addr = 15'h0ABC;
        go(3'b001, 1);
        go(3'b111, 4);
        chk(int_addr, 15'h0ABC);
    endtask
    task automatic t_clear;
        ext_addr = 15'h2222;
        go(3'b000, 1);
        go(3'b111, 4);
        chk(int_addr, 15'h0000);
    endtask
    task automatic t_mode(input logic m, input logic [14:0] lag);
        sel = m;
        go(3'b101, 6);
        chk(pipe, m);
        chk(rdata, {3'h5, ~(int_addr - lag)});
        go(3'b111, 4);
        chk(rdata, {3'h5, ~int_addr});
    endtask
    task summarize;
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #100us;
        errors++;
        summarize();
    end
    initial begin
        repeat (10) @(negedge ref_clk);
        srst = 1'b0;
        go(3'b111, 2);
        t_load();
        t_clear();
        t_mode(1'b0, 15'h0001);
        t_mode(1'b1, 15'h0002);
        summarize();
    end
endmodule
